// ### inc/bid_regs.vh
// Constants for the byte instruction decoder
`ifndef BID_REGS_VH
`define BID_REGS_VH
// Primary function codes
`define BID_FN_JUMP 4'h0
`define BID_FN_LOCAL_PTR 4'h1
`define BID_FN_PFX 4'h2
`define BID_FN_LOAD_NONLOCAL 4'h3
`define BID_FN_LOAD_CONST 4'h4
`define BID_FN_NONLOCAL_PTR 4'h5
`define BID_FN_NFX 4'h6
`define BID_FN_LOAD_LOCAL 4'h7
`define BID_FN_ADD_CONST 4'h8
`define BID_FN_CALL 4'h9
`define BID_FN_COND_JUMP 4'ha
`define BID_FN_ADJ_WSPACE 4'hb
`define BID_FN_EQ_CONST 4'hc
`define BID_FN_STORE_LOCAL 4'hd
`define BID_FN_STORE_NONLOCAL 4'he
`define BID_FN_OPERATE 4'hf
// Secondary operation selectors (operand value of an operate byte)
`define BID_OP_SAVE_HI 32'h0000003e
`define BID_OP_SAVE_LO 32'h0000003d
`define BID_OP_ST_HI_FRONT 32'h00000018
`define BID_OP_ST_HI_BACK 32'h00000050
`define BID_OP_ST_LO_FRONT 32'h0000001c
`define BID_OP_ST_LO_BACK 32'h00000017
`define BID_OP_TEST_ANAL 32'h0000002a
`define BID_OP_ST_TIMER 32'h00000054
`define BID_OP_ADD 32'h00000005
`define BID_OP_SUB 32'h0000000c
`define BID_OP_MUL 32'h00000053
`define BID_OP_DIV 32'h0000002c
`define BID_OP_REM 32'h0000001f
// Nominal cycle counts
`define BID_CYC_SAVE_Q 6'd3
`define BID_CYC_ST_PTR 6'd1
`define BID_CYC_JUMP 6'd5
`define BID_CYC_CALL 6'd8
`define BID_CYC_MEM2 6'd2
`define BID_CYC_ONE 6'd1
`define BID_CYC_MUL 6'd4
`define BID_CYC_DIV_MAX 6'd37
`define BID_CYC_REM_MAX 6'd40
// Illegal instruction error code handed to the trap handler
`define BID_ERR_ILLEGAL 4'h1
// Feature tag bit positions
`define BID_F_INTEGER 0
`define BID_F_LOAD 1
`define BID_F_STORE 2
`define BID_F_OVERFLOW 3
`define BID_F_INTR 4
`define BID_F_ABORT 5
`define BID_F_DESCHED 6
`define BID_F_TSLICE 7
`define BID_FEAT_W 8
`endif

// ### logic/bid_decoder.v
// Byte instruction decoder with operand prefixing and cycle timing
//
// Summary of operation
// [RULE_01] Byte splits into function and data nibbles
// [RULE_02] Operand below 16 needs single byte
// [RULE_03] One prefix byte per extra nibble
// [RULE_04] Negative operand starts with negative prefix
// [RULE_05] Prefix ORs and shifts; others consume, clear
// [RULE_06] Sixteen function codes select primary operations
// [RULE_07] Undefined encodings trapped with error code
// [RULE_08] Tag integer, load, store, overflow trap causes; only the overflow tag is ever set
// [RULE_09] Tag abort, interrupt, deschedule, timeslice properties; the interrupt tag is never set
// [RULE_10] Nominal counts assume two-cycle uncontended memory
// [RULE_11] Data-dependent operations take variable cycle count
// [RULE_12] Stall until previous read value returns
// [RULE_13] At most two memory operations outstanding
// [RULE_14] Data accesses yield to fetch and subsystems
// [RULE_15] Flow redirect waits for target fetch
// [RULE_16] Queue register saves take three cycles
// [RULE_17] High queue pointer stores take one cycle
// [RULE_18] Low queue pointer stores take one cycle
// [RULE_19] Operate uses accumulated operand as selector
`timescale 1ns/100ps
`include "bid_regs.vh"
module bid_decoder #(
  parameter OPW = 32
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Instruction fetch side
  input wire ibyte_valid_i,
  input wire [7:0] ibyte_i,
  output wire ibyte_ready_o,
  input wire target_ready_i,
  // Execution control
  input wire [5:0] var_cycles_i,
  input wire trap_handler_en_i,
  // Memory interface
  input wire mem_other_req_i,
  input wire mem_done_i,
  input wire read_pending_i,
  // Decoded instruction
  output reg instr_valid_o,
  output reg [3:0] func_o,
  output reg [OPW-1:0] operand_o,
  output reg [OPW-1:0] sec_op_o,
  output reg is_secondary_o,
  output reg [`BID_FEAT_W-1:0] features_o,
  output reg [5:0] cycles_o,
  output reg uses_mem_o,
  output reg redirect_o,
  // Trap reporting
  output reg illegal_o,
  output reg [3:0] err_code_o,
  output reg integer_fault_trap_o,
  output reg load_fault_trap_o,
  output reg store_fault_trap_o,
  // Status
  output wire busy_o,
  output reg [1:0] mem_outstanding_o
);

  // ==========================================================
  // Byte split and operand accumulation
  wire [3:0] fn = ibyte_i[7:4]; // RULE_01
  wire [3:0] nib = ibyte_i[3:0]; // RULE_01
  // Prefix bytes wait here; a reset drops a half-built operand
  reg [OPW-1:0] oreg_reg;
  wire [OPW-1:0] opnd = oreg_reg | {{(OPW-4){1'b0}}, nib}; // RULE_05
  wire is_pfx = (fn == `BID_FN_PFX);
  wire is_nfx = (fn == `BID_FN_NFX);

  // ==========================================================
  // Execution state: a cycle counter and a redirect wait
  localparam ST_IDLE = 2'd0;
  localparam ST_EXEC = 2'd1;
  localparam ST_REDIR = 2'd2;
  reg [1:0] state_reg;
  reg [5:0] cnt_reg;
  reg redir_pend_reg;

  // Memory ops: block a third while two are in flight
  // Conservative: a completion in the same cycle does not free the slot
  wire mem_full = (mem_outstanding_o == 2'd2); // RULE_13

  // ==========================================================
  // Combinational classification of the incoming byte
  reg d_mem;
  reg d_redir;
  reg d_illegal;
  reg d_var;
  reg [5:0] d_cyc;
  reg [`BID_FEAT_W-1:0] d_feat;
  reg d_needs_stack;
  always @* begin
    d_mem = 1'b0;
    d_redir = 1'b0;
    d_illegal = 1'b0;
    d_var = 1'b0;
    d_cyc = `BID_CYC_ONE;
    d_feat = {`BID_FEAT_W{1'b0}};
    d_needs_stack = 1'b0;
    case (fn) // RULE_06
      `BID_FN_JUMP: begin
        d_cyc = `BID_CYC_JUMP;
        d_redir = 1'b1; // RULE_15
        d_feat[`BID_F_DESCHED] = 1'b1; // RULE_09
        d_feat[`BID_F_TSLICE] = 1'b1; // RULE_09
      end
      `BID_FN_LOAD_NONLOCAL: begin
        d_cyc = `BID_CYC_MEM2; // RULE_10
        d_mem = 1'b1;
        d_needs_stack = 1'b1;
      end
      `BID_FN_LOAD_LOCAL: begin
        d_mem = 1'b1;
      end
      `BID_FN_STORE_LOCAL: begin
        d_mem = 1'b1;
        d_needs_stack = 1'b1;
      end
      `BID_FN_STORE_NONLOCAL: begin
        d_cyc = `BID_CYC_MEM2;
        d_mem = 1'b1;
        d_needs_stack = 1'b1;
      end
      `BID_FN_ADD_CONST: begin
        d_needs_stack = 1'b1;
        d_feat[`BID_F_OVERFLOW] = 1'b1; // RULE_08
      end
      `BID_FN_CALL: begin
        d_cyc = `BID_CYC_CALL;
        d_mem = 1'b1;
        d_redir = 1'b1; // RULE_15
      end
      `BID_FN_COND_JUMP: begin
        // Taken jump length is data dependent: 1 or 5
        // Always waits for the fetch unit, even when not taken: costs
        // a few cycles but never issues from a stale byte stream
        d_needs_stack = 1'b1;
        d_var = 1'b1; // RULE_11
        d_redir = 1'b1;
      end
      `BID_FN_ADJ_WSPACE: begin
        d_cyc = `BID_CYC_MEM2;
      end
      `BID_FN_EQ_CONST: begin
        d_needs_stack = 1'b1;
      end
      `BID_FN_OPERATE: begin
        // Secondary selector is the whole accumulated operand
        d_needs_stack = 1'b1;
        case (opnd) // RULE_19
          `BID_OP_SAVE_HI: begin
            d_cyc = `BID_CYC_SAVE_Q; // RULE_16
            d_mem = 1'b1;
          end
          `BID_OP_SAVE_LO: begin
            d_cyc = `BID_CYC_SAVE_Q; // RULE_16
            d_mem = 1'b1;
          end
          `BID_OP_ST_HI_FRONT: d_cyc = `BID_CYC_ST_PTR; // RULE_17
          `BID_OP_ST_HI_BACK: d_cyc = `BID_CYC_ST_PTR; // RULE_17
          `BID_OP_ST_LO_FRONT: d_cyc = `BID_CYC_ST_PTR; // RULE_18
          `BID_OP_ST_LO_BACK: d_cyc = `BID_CYC_ST_PTR; // RULE_18
          `BID_OP_TEST_ANAL: d_cyc = `BID_CYC_MEM2;
          `BID_OP_ST_TIMER: d_cyc = `BID_CYC_MEM2;
          `BID_OP_ADD, `BID_OP_SUB: begin
            d_feat[`BID_F_ABORT] = 1'b1; // RULE_09
            d_feat[`BID_F_OVERFLOW] = 1'b1; // RULE_08
          end
          `BID_OP_MUL: begin
            d_cyc = `BID_CYC_MUL;
            d_feat[`BID_F_ABORT] = 1'b1;
            d_feat[`BID_F_OVERFLOW] = 1'b1;
          end
          `BID_OP_DIV, `BID_OP_REM: begin
            d_var = 1'b1; // RULE_11
            d_cyc = (opnd == `BID_OP_DIV) ? `BID_CYC_DIV_MAX : `BID_CYC_REM_MAX;
            d_feat[`BID_F_ABORT] = 1'b1;
            d_feat[`BID_F_OVERFLOW] = 1'b1;
          end
          default: begin
            // Outside the small secondary table; the operation never runs,
            // so it must not hold issue waiting for a stack value
            d_illegal = 1'b1; // RULE_07
            d_needs_stack = 1'b0;
          end
        endcase
      end
      default: begin
        d_cyc = `BID_CYC_ONE;
      end
    endcase
  end

  // ==========================================================
  // Issue gating
  wire issue_ok = (state_reg == ST_IDLE);
  wire stack_wait = d_needs_stack & read_pending_i; // RULE_12
  wire mem_wait = d_mem & (mem_full | mem_other_req_i); // RULE_13 RULE_14
  wire prefix_byte = is_pfx | is_nfx;
  // Prefixes never touch memory or the stack, so they are taken whenever the decoder is idle
  assign ibyte_ready_o = issue_ok & (prefix_byte | (~stack_wait & ~mem_wait));
  wire take = ibyte_valid_i & ibyte_ready_o;
  wire exec_take = take & ~prefix_byte;
  assign busy_o = (state_reg != ST_IDLE);

  // Effective cycle count, data-dependent ones come from the executor
  // A zero count would mean no execution at all, so it reads as one
  wire [5:0] eff_cyc = d_var ? ((var_cycles_i == 6'd0) ? `BID_CYC_ONE : var_cycles_i) : d_cyc; // RULE_11

  // ==========================================================
  // Sequential core
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      oreg_reg <= {OPW{1'b0}};
      state_reg <= ST_IDLE;
      cnt_reg <= 6'd0;
      redir_pend_reg <= 1'b0;
      instr_valid_o <= 1'b0;
      func_o <= 4'h0;
      operand_o <= {OPW{1'b0}};
      sec_op_o <= {OPW{1'b0}};
      is_secondary_o <= 1'b0;
      features_o <= {`BID_FEAT_W{1'b0}};
      cycles_o <= 6'd0;
      uses_mem_o <= 1'b0;
      redirect_o <= 1'b0;
      illegal_o <= 1'b0;
      err_code_o <= 4'h0;
      integer_fault_trap_o <= 1'b0;
      load_fault_trap_o <= 1'b0;
      store_fault_trap_o <= 1'b0;
      mem_outstanding_o <= 2'd0;
    end else begin
      instr_valid_o <= 1'b0;
      illegal_o <= 1'b0;
      if (take) begin
        if (is_pfx) begin
          oreg_reg <= opnd << 4; // RULE_03 RULE_05
        end else if (is_nfx) begin
          oreg_reg <= (~opnd) << 4; // RULE_04 RULE_05
        end else begin
          // Single byte when no prefix ran, operand is just the nibble
          oreg_reg <= {OPW{1'b0}}; // RULE_02 RULE_05
          instr_valid_o <= 1'b1;
          func_o <= fn;
          operand_o <= opnd;
          is_secondary_o <= (fn == `BID_FN_OPERATE);
          sec_op_o <= (fn == `BID_FN_OPERATE) ? opnd : {OPW{1'b0}}; // RULE_19
          features_o <= d_feat;
          cycles_o <= eff_cyc;
          uses_mem_o <= d_mem;
          redirect_o <= d_redir;
          illegal_o <= d_illegal & trap_handler_en_i; // RULE_07
          err_code_o <= (d_illegal & trap_handler_en_i) ? `BID_ERR_ILLEGAL : 4'h0;
          integer_fault_trap_o <= d_feat[`BID_F_INTEGER]; // RULE_08
          load_fault_trap_o <= d_feat[`BID_F_LOAD];
          store_fault_trap_o <= d_feat[`BID_F_STORE];
        end
      end
      // Outstanding memory count: issue and completion may coincide
      // A completion with nothing in flight is dropped, so a stray
      // pulse from the far side cannot wrap the count
      case ({exec_take & d_mem, mem_done_i & (mem_outstanding_o != 2'd0)}) // RULE_13
        2'b10: mem_outstanding_o <= mem_outstanding_o + 2'd1;
        2'b01: mem_outstanding_o <= mem_outstanding_o - 2'd1;
        default: mem_outstanding_o <= mem_outstanding_o;
      endcase
      case (state_reg)
        ST_IDLE: begin
          if (exec_take) begin
            redir_pend_reg <= d_redir;
            if (eff_cyc > 6'd1) begin
              cnt_reg <= eff_cyc - 6'd1; // RULE_10
              state_reg <= ST_EXEC;
            end else if (d_redir) begin
              state_reg <= ST_REDIR; // RULE_15
            end
          end
        end
        ST_EXEC: begin
          cnt_reg <= cnt_reg - 6'd1;
          if (cnt_reg == 6'd1) begin
            state_reg <= redir_pend_reg ? ST_REDIR : ST_IDLE;
          end
        end
        ST_REDIR: begin
          // Hold next issue until the fetch unit has the new target
          if (target_ready_i) begin
            state_reg <= ST_IDLE; // RULE_15
            redir_pend_reg <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// ### testbench/bid_decoder_asserts.sv
// Port checker for the byte instruction decoder
`timescale 1ns/100ps
`include "bid_regs.vh"
module bid_decoder_asserts (
  input wire clk_i,
  input wire rst_b_i,
  input wire ibyte_valid_i,
  input wire [7:0] ibyte_i,
  input wire ibyte_ready_o,
  input wire trap_handler_en_i,
  input wire mem_other_req_i,
  input wire read_pending_i,
  input wire instr_valid_o,
  input wire [3:0] func_o,
  input wire [31:0] sec_op_o,
  input wire [7:0] features_o,
  input wire [5:0] cycles_o,
  input wire redirect_o,
  input wire illegal_o,
  input wire [3:0] err_code_o,
  input wire [1:0] mem_outstanding_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire take_w = ibyte_valid_i & ibyte_ready_o;
  wire pfx_w = ibyte_i[7:4] == `BID_FN_PFX || ibyte_i[7:4] == `BID_FN_NFX;
  sequence s_hold2;
    !ibyte_ready_o [*2];
  endsequence
  chk_prefix_quiet: assert property (take_w && pfx_w |=> !instr_valid_o)
    else $error("prefix byte produced an instruction");
  chk_answer_func: assert property (take_w && !pfx_w |=> instr_valid_o && func_o == $past(ibyte_i[7:4]))
    else $error("decoded function does not follow byte");
  chk_save_cycles: assert property (instr_valid_o && sec_op_o == `BID_OP_SAVE_HI |-> cycles_o == 6'd3 ##0 s_hold2)
    else $error("queue save not three cycles");
  chk_ptr_cycles: assert property (instr_valid_o && sec_op_o inside {32'h18, 32'h50, 32'h1c, 32'h17} |-> cycles_o == 6'd1)
    else $error("pointer store not one cycle");
  chk_illegal_code: assert property (illegal_o |-> instr_valid_o && err_code_o == `BID_ERR_ILLEGAL && $past(trap_handler_en_i))
    else $error("illegal report malformed");
  chk_stack_stall: assert property (read_pending_i && ibyte_i[7:4] == `BID_FN_LOAD_NONLOCAL |-> !ibyte_ready_o)
    else $error("load taken while read pending");
  chk_two_mem: assert property (mem_outstanding_o == 2'd2 && ibyte_i[7:4] == `BID_FN_LOAD_NONLOCAL |-> !ibyte_ready_o)
    else $error("third memory operation taken");
  chk_yield_mem: assert property (mem_other_req_i && ibyte_i[7:4] == `BID_FN_STORE_NONLOCAL |-> !ibyte_ready_o)
    else $error("store did not yield memory");
  chk_redirect_wait: assert property (instr_valid_o && redirect_o |=> !ibyte_ready_o)
    else $error("no wait after redirect");
  chk_add_tags: assert property (instr_valid_o && sec_op_o == `BID_OP_ADD |-> features_o[5] && features_o[3])
    else $error("add missing abort or overflow tag");
endmodule
bind bid_decoder bid_decoder_asserts u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .ibyte_valid_i(ibyte_valid_i),
  .ibyte_i(ibyte_i), .ibyte_ready_o(ibyte_ready_o), .trap_handler_en_i(trap_handler_en_i),
  .mem_other_req_i(mem_other_req_i), .read_pending_i(read_pending_i), .instr_valid_o(instr_valid_o),
  .func_o(func_o), .sec_op_o(sec_op_o), .features_o(features_o), .cycles_o(cycles_o), .redirect_o(redirect_o),
  .illegal_o(illegal_o), .err_code_o(err_code_o), .mem_outstanding_o(mem_outstanding_o));

// ### testbench/bid_mem_model.sv
// Memory completion and fetch target model facing the decoder
`timescale 1ns/100ps
module bid_mem_model (
  // Clock, reset and pace
  input wire clk_i,
  input wire rst_b_i,
  input wire slow_i,
  // Decoder side
  input wire [1:0] mem_outstanding_i,
  input wire redirect_i,
  output reg mem_done_o,
  output reg target_ready_o
);
  reg [2:0] mem_cnt_reg;
  reg [1:0] tgt_cnt_reg;
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      mem_done_o <= 1'b0;
      target_ready_o <= 1'b0;
      mem_cnt_reg <= 3'h0;
      tgt_cnt_reg <= 2'h0;
    end else begin
      // Internal memory answers in two cycles, slow external memory in six
      mem_cnt_reg <= (mem_outstanding_i == 2'h0 || mem_done_o) ? 3'h0 : mem_cnt_reg + 3'h1;
      mem_done_o <= mem_outstanding_i != 2'h0 && !mem_done_o && mem_cnt_reg == (slow_i ? 3'h5 : 3'h1);
      tgt_cnt_reg <= redirect_i ? tgt_cnt_reg + 2'h1 : 2'h0;
      target_ready_o <= redirect_i && tgt_cnt_reg == 2'h2;
    end
  end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the byte instruction decoder
`timescale 1ns/100ps
module tb;
  reg clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg ibyte_valid_i = 1'b0;
  reg [7:0] ibyte_i = 8'h00;
  reg [5:0] var_cycles_i = 6'h01;
  reg trap_handler_en_i = 1'b0;
  reg mem_other_req_i = 1'b0;
  reg read_pending_i = 1'b0;
  reg slow = 1'b0;
  reg bad = 1'b0;
  wire ibyte_ready_o, busy_o, instr_valid_o, is_secondary_o, uses_mem_o, redirect_o, illegal_o, mem_done_i;
  wire integer_fault_trap_o, load_fault_trap_o, store_fault_trap_o, target_ready_i;
  wire [3:0] func_o, err_code_o;
  wire [31:0] operand_o, sec_op_o;
  wire [7:0] features_o;
  wire [5:0] cycles_o;
  wire [1:0] mem_outstanding_o;
  integer mismatches = 0;
  integer tests_run = 0;
  integer i, k, n;
  reg [31:0] seed = 32'hc9b4;
  reg [31:0] oreg, code;
  localparam [15:0] FN = 16'h148c;
  localparam [95:0] SEC = {16'h23fe, 16'h23fd, 16'h21f8, 16'h25f0, 16'h21fc, 16'h21f7};
  initial forever #2.5 clk_i = ~clk_i;
  bid_decoder u_bid_decoder (.clk_i(clk_i), .rst_b_i(rst_b_i), .ibyte_valid_i(ibyte_valid_i), .ibyte_i(ibyte_i),
    .ibyte_ready_o(ibyte_ready_o), .target_ready_i(target_ready_i), .var_cycles_i(var_cycles_i),
    .trap_handler_en_i(trap_handler_en_i), .mem_other_req_i(mem_other_req_i), .mem_done_i(mem_done_i),
    .read_pending_i(read_pending_i), .instr_valid_o(instr_valid_o), .func_o(func_o), .operand_o(operand_o),
    .sec_op_o(sec_op_o), .is_secondary_o(is_secondary_o), .features_o(features_o), .cycles_o(cycles_o),
    .uses_mem_o(uses_mem_o), .redirect_o(redirect_o), .illegal_o(illegal_o), .err_code_o(err_code_o),
    .integer_fault_trap_o(integer_fault_trap_o), .load_fault_trap_o(load_fault_trap_o),
    .store_fault_trap_o(store_fault_trap_o), .busy_o(busy_o), .mem_outstanding_o(mem_outstanding_o));
  bid_mem_model u_bid_mem_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
    .mem_outstanding_i(mem_outstanding_o), .redirect_i(redirect_o), .mem_done_o(mem_done_i),
    .target_ready_o(target_ready_i));
  // ==========
  // Expectations and transfers
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [31:0] fold(input [31:0] o, input [7:0] b);
    case (b[7:4])
      4'h2: fold = (o | b[3:0]) << 4;
      4'h6: fold = (~(o | b[3:0])) << 4;
      default: fold = o | b[3:0];
    endcase
  endfunction
  // Memory-using primaries, plus the two queue saves among the secondaries
  function mem_use(input [3:0] f, input [31:0] o);
    mem_use = f == 4'h3 || f == 4'h7 || f == 4'h9 || f == 4'hd || f == 4'he || (f == 4'hf && (o == 32'h3e || o == 32'h3d));
  endfunction
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Byte stays offered until ready is seen high before an edge
  task send(input [7:0] b);
    begin
      ibyte_i = b;
      ibyte_valid_i = 1'b1;
      n = 0;
      @(negedge clk_i);
      while (ibyte_ready_o !== 1'b1) begin
        n = n + 1;
        if (n > 300) begin
          mismatches = mismatches + 1;
          end_of_test;
        end
        @(negedge clk_i);
      end
      @(posedge clk_i);
      #1;
    end
  endtask
  task run(input [31:0] c, input integer nb);
    begin
      oreg = 32'h0;
      for (k = nb - 1; k >= 0; k = k - 1) begin
        oreg = fold(oreg, c[8*k +: 8]);
        send(c[8*k +: 8]);
      end
      ibyte_valid_i = 1'b0;
      chk(instr_valid_o, 1);
      chk(func_o, c[7:4]);
      chk(operand_o, oreg);
      chk(sec_op_o, c[7:4] == 4'hf ? oreg : 32'h0);
      chk(illegal_o, bad);
      chk(err_code_o, bad ? 4'h1 : 4'h0);
      chk(is_secondary_o, c[7:4] == 4'hf);
      chk(uses_mem_o, mem_use(c[7:4], oreg));
      chk({integer_fault_trap_o, load_fault_trap_o, store_fault_trap_o}, 0);
      @(posedge clk_i);
      #1;
      chk(instr_valid_o, 0);
    end
  endtask
  task blocked(input [7:0] b);
    begin
      ibyte_i = b;
      ibyte_valid_i = 1'b1;
      repeat (3) begin
        @(negedge clk_i);
        chk(ibyte_ready_o, 0);
      end
      @(posedge clk_i);
      #1;
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    run(32'h6141, 2);
    run(32'h292847, 3);
    for (i = 0; i < 40; i = i + 1) begin
      seed = lfsr(lfsr(lfsr(seed)));
      var_cycles_i = seed[25:20];
      code = 32'h0;
      for (k = 0; k < seed[1:0]; k = k + 1)
        code = {code[23:0], seed[k + 2] ? 4'h6 : 4'h2, seed[15:12]};
      code = {code[23:0], FN[4*seed[9:8] +: 4], seed[19:16]};
      run(code, seed[1:0] + 1);
      chk(cycles_o, 1);
      chk(features_o, code[7:4] == 4'h8 ? 8'h08 : 8'h00);
    end
    for (i = 0; i < 6; i = i + 1) begin
      run(SEC[16*i +: 16], 2);
      chk(cycles_o, i > 3 ? 3 : 1);
    end
    var_cycles_i = 6'd20;
    run(32'h22fc, 2);
    chk(cycles_o, 20);
    chk(busy_o, 1);
    chk(features_o[5] & features_o[3], 1);
    run(32'hf5, 1);
    run(32'h05, 1);
    chk(redirect_o & features_o[6] & features_o[7], 1);
    chk(busy_o, 1);
    run(32'h25f3, 2);
    chk(cycles_o, 4);
    chk(features_o, 8'h28);
    run(32'h22fa, 2);
    chk(cycles_o, 2);
    var_cycles_i = 6'd5;
    run(32'ha3, 1);
    chk(cycles_o, 5);
    chk(redirect_o, 1);
    run(32'h97, 1);
    chk(cycles_o, 8);
    chk(redirect_o, 1);
    trap_handler_en_i = 1'b1;
    bad = 1'b1;
    run(32'h2bf7, 2);
    trap_handler_en_i = 1'b0;
    bad = 1'b0;
    run(32'h2bf7, 2);
    chk(busy_o, 0);
    read_pending_i = 1'b1;
    blocked(8'h30);
    read_pending_i = 1'b0;
    run(32'h30, 1);
    mem_other_req_i = 1'b1;
    blocked(8'he0);
    mem_other_req_i = 1'b0;
    run(32'he0, 1);
    // Reset in mid-run drops a half-built operand and the memory count
    send(8'h29);
    ibyte_valid_i = 1'b0;
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({busy_o, instr_valid_o, mem_outstanding_o}, 0);
    rst_b_i = 1'b1;
    run(32'h47, 1);
    slow = 1'b1;
    run(32'h30, 1);
    run(32'h30, 1);
    chk(mem_outstanding_o, 2);
    blocked(8'h30);
    for (i = 0; i < 4; i = i + 1)
      run(32'h30, 1);
    end_of_test;
  end
endmodule
